// [ifd_decoder.sv]
// instruction format and operand decoder for a soft processor core
`timescale 1ns/10ps
module ifd_decoder #(
   parameter int unsigned DATA_W = 32
) (
   input  wire logic                          clk_in,
   input  wire logic                          sys_rst_in,
   input  wire logic                          insn_valid_in,
   input  wire logic [ifd_pkg::INSN_W-1:0]    insn_in,
   output logic                               insn_ready_out,
   input  wire logic                          exec_ready_in,
   output logic                               dec_valid_out,
   output ifd_pkg::ifd_fmt_t                  fmt_out,
   output logic [ifd_pkg::REG_IDX_W-1:0]      first_source_reg_out,
   output logic [ifd_pkg::REG_IDX_W-1:0]      second_source_reg_out,
   output logic [ifd_pkg::REG_IDX_W-1:0]      dest_reg_out,
   output logic                               second_source_used_out,
   output logic                               dest_write_out,
   output logic [DATA_W-1:0]                  imm_out,
   output logic                               imm_prefixed_out,
   output logic [DATA_W-1:0]                  src_mask_out,
   output logic [DATA_W-1:0]                  dest_mask_out,
   output logic [ifd_pkg::SPR_NUM_W-1:0]      special_register_number_out,
   output ifd_pkg::ifd_spr_sel_t              spr_sel_out,
   output logic [3:0]                         version_idx_out
);
   import ifd_pkg::*;

   localparam int unsigned LOW_W   = 32;
   localparam bit          IS_WIDE = (DATA_W > LOW_W);

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   logic [5:0]            opc;
   logic                  is_prefix;
   ifd_fmt_t              fmt;
   logic [IMM_HALF_W-1:0] imm_lo;
   logic                  wide;
   logic                  take;
   ifd_pfx_state_t        pfx_state;
   logic [IMM_HALF_W-1:0] pfx_half;

   assign opc       = insn_in[OPC_HI:OPC_LO];
   assign is_prefix = (opc == PREFIX_OPC);
   assign fmt       = insn_in[IMM_FMT_BIT] ? IFD_FMT_IMM : IFD_FMT_REG;
   assign imm_lo    = insn_in[IMM_HI:IMM_LO];
   assign wide      = insn_in[WIDE_BIT];
   assign insn_ready_out = exec_ready_in || !dec_valid_out;
   assign take      = insn_valid_in && insn_ready_out;

   // ----------------------------------------------------------------
   // prefix holding
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pfx_state <= IFD_PFX_IDLE;
         pfx_half  <= '0;
      end else if (take) begin
         case (pfx_state)
            IFD_PFX_IDLE: begin
               if (is_prefix) begin
                  pfx_state <= IFD_PFX_HELD;
                  pfx_half  <= imm_lo;
               end
            end
            IFD_PFX_HELD: begin
               if (is_prefix) begin
                  pfx_half <= imm_lo;
               end else begin
                  pfx_state <= IFD_PFX_IDLE;
               end
            end
            default: pfx_state <= IFD_PFX_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // immediate assembly
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] next_imm;
   logic              next_pfx_used;

   always_comb begin
      next_imm      = {{(DATA_W-IMM_HALF_W){imm_lo[IMM_HALF_W-1]}}, imm_lo};
      next_pfx_used = 1'b0;
      if (pfx_state == IFD_PFX_HELD && fmt == IFD_FMT_IMM) begin
         next_imm = {{(DATA_W-LOW_W){pfx_half[IMM_HALF_W-1]}},
                     pfx_half, imm_lo};
         next_pfx_used = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // operand width masks
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] low_mask;
   logic [DATA_W-1:0] next_mask;

   assign low_mask  = {{(DATA_W-LOW_W){1'b0}}, {LOW_W{1'b1}}};
   assign next_mask = (!IS_WIDE || wide) ? '1 : low_mask;

   // ----------------------------------------------------------------
   // special register mapping
   // ----------------------------------------------------------------
   logic [SPR_NUM_W-1:0] spr_num;
   ifd_spr_sel_t         next_sel;
   logic [3:0]           next_ver;
   logic [SPR_NUM_W-1:0] ver_off;

   assign spr_num = insn_in[SPR_SEL_HI:SPR_SEL_LO];
   assign ver_off = spr_num - SPR_VER_BASE;

   always_comb begin
      next_sel = IFD_SEL_NONE;
      next_ver = '0;
      case (spr_num)
         SPR_PC:      next_sel = IFD_SEL_PC;
         SPR_STATE:   next_sel = IFD_SEL_STATE;
         SPR_FCAUSE:  next_sel = IFD_SEL_FCAUSE;
         SPR_FADDR:   next_sel = IFD_SEL_FADDR;
         SPR_FSTAT:   next_sel = IFD_SEL_FSTAT;
         SPR_BTARGET: next_sel = IFD_SEL_BTARGET;
         default: begin
            if (spr_num >= SPR_VER_BASE &&
                ver_off <= {10'h000, VER_IDX_MAX}) begin
               next_sel = IFD_SEL_VERSION;
               next_ver = ver_off[3:0];
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // output register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dec_valid_out <= 1'b0;
      end else if (insn_ready_out) begin
         dec_valid_out <= insn_valid_in && !is_prefix;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fmt_out                     <= IFD_FMT_REG;
         first_source_reg_out        <= '0;
         second_source_reg_out       <= '0;
         dest_reg_out                <= '0;
         second_source_used_out      <= 1'b0;
         dest_write_out              <= 1'b0;
         imm_out                     <= '0;
         imm_prefixed_out            <= 1'b0;
         src_mask_out                <= '0;
         dest_mask_out               <= '0;
         special_register_number_out <= '0;
         spr_sel_out                 <= IFD_SEL_NONE;
         version_idx_out             <= '0;
      end else if (take && !is_prefix) begin
         fmt_out               <= fmt;
         first_source_reg_out  <= insn_in[SRCA_HI:SRCA_LO];
         second_source_reg_out <= insn_in[SRCB_HI:SRCB_LO];
         dest_reg_out          <= insn_in[DEST_HI:DEST_LO];
         second_source_used_out <= (fmt == IFD_FMT_REG);
         dest_write_out        <= 1'b1;
         imm_out               <= next_imm;
         imm_prefixed_out      <= next_pfx_used;
         src_mask_out          <= next_mask;
         dest_mask_out         <= next_mask;
         special_register_number_out <= spr_num;
         spr_sel_out           <= next_sel;
         version_idx_out       <= next_ver;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_prefix_taken;
      take && is_prefix;
   endsequence
   sequence s_imm_taken;
      take && !is_prefix && fmt == IFD_FMT_IMM;
   endsequence

   AST_PREFIX_WIDENS: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      s_prefix_taken ##1 s_imm_taken |=> imm_prefixed_out &&
         imm_out[LOW_W-1:IMM_HALF_W] == $past(pfx_half))
      else $error("prefixed immediate not widened");
   AST_PREFIX_ONCE: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      s_imm_taken ##1 s_imm_taken |=> !imm_prefixed_out)
      else $error("prefix half reused");
   AST_PLAIN_SEXT: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      (s_imm_taken and pfx_state == IFD_PFX_IDLE) |=>
         imm_out[DATA_W-1:IMM_HALF_W] ==
         {(DATA_W-IMM_HALF_W){imm_out[IMM_HALF_W-1]}})
      else $error("plain immediate not sign extended");
   AST_FORMAT: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      take && !is_prefix |=> fmt_out == $past(fmt))
      else $error("format not classified");
   AST_TWO_SOURCES: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      dec_valid_out |-> second_source_used_out == (fmt_out == IFD_FMT_REG))
      else $error("second source use wrong");
   AST_ONE_DEST: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      dec_valid_out |-> dest_write_out)
      else $error("destination not written");
   AST_MASK_WIDTH: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      take && !is_prefix && !wide |=> src_mask_out == low_mask)
      else $error("source width wrong");
   AST_DEST_MASK: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      dec_valid_out |-> dest_mask_out == src_mask_out)
      else $error("destination width wrong");
   AST_SPR_STATE: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      take && !is_prefix && spr_num == SPR_STATE |=>
         spr_sel_out == IFD_SEL_STATE)
      else $error("state word mapping wrong");
   AST_SPR_PC: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      take && !is_prefix && spr_num == SPR_PC |=> spr_sel_out == IFD_SEL_PC)
      else $error("pc mapping wrong");
   AST_SPR_VER: assert property (@(posedge clk_in)
      disable iff (sys_rst_in)
      spr_sel_out == IFD_SEL_VERSION |-> special_register_number_out ==
         SPR_VER_BASE + {10'h000, version_idx_out})
      else $error("version mapping wrong");
endmodule // ifd_decoder

// [ifd_pkg.sv]
// constants and types for the instruction format and operand decoder
package ifd_pkg;
   localparam int unsigned INSN_W       = 32;
   localparam int unsigned REG_IDX_W    = 5;
   localparam int unsigned IMM_HALF_W   = 16;
   localparam int unsigned SPR_NUM_W    = 14;
   localparam int unsigned OPC_HI       = 31;
   localparam int unsigned OPC_LO       = 26;
   localparam int unsigned DEST_HI      = 25;
   localparam int unsigned DEST_LO      = 21;
   localparam int unsigned SRCA_HI      = 20;
   localparam int unsigned SRCA_LO      = 16;
   localparam int unsigned SRCB_HI      = 15;
   localparam int unsigned SRCB_LO      = 11;
   localparam int unsigned IMM_HI       = 15;
   localparam int unsigned IMM_LO       = 0;
   localparam int unsigned WIDE_BIT     = 8;
   localparam int unsigned IMM_FMT_BIT  = 29;
   localparam int unsigned SPR_SEL_HI   = 13;
   localparam int unsigned SPR_SEL_LO   = 0;
   localparam logic [5:0]  PREFIX_OPC   = 6'h2C;
   localparam logic [13:0] SPR_PC       = 14'h0000;
   localparam logic [13:0] SPR_STATE    = 14'h0001;
   localparam logic [13:0] SPR_FADDR    = 14'h0003;
   localparam logic [13:0] SPR_FCAUSE   = 14'h0005;
   localparam logic [13:0] SPR_FSTAT    = 14'h0007;
   localparam logic [13:0] SPR_BTARGET  = 14'h000B;
   localparam logic [13:0] SPR_VER_BASE = 14'h2000;
   localparam logic [3:0]  VER_IDX_MAX  = 4'hC;

   typedef enum logic [0:0] {
      IFD_FMT_REG = 1'b0,
      IFD_FMT_IMM = 1'b1
   } ifd_fmt_t;

   typedef enum logic [3:0] {
      IFD_SEL_NONE    = 4'b0000,
      IFD_SEL_PC      = 4'b0001,
      IFD_SEL_STATE   = 4'b0010,
      IFD_SEL_FCAUSE  = 4'b0011,
      IFD_SEL_FADDR   = 4'b0100,
      IFD_SEL_FSTAT   = 4'b0101,
      IFD_SEL_VERSION = 4'b0110,
      IFD_SEL_BTARGET = 4'b0111
   } ifd_spr_sel_t;

   typedef enum logic [0:0] {
      IFD_PFX_IDLE = 1'b0,
      IFD_PFX_HELD = 1'b1
   } ifd_pfx_state_t;
endpackage

// [ifd_fetch_model.sv]
// fetch stage model that offers queued instruction words
`timescale 1ns/10ps
module ifd_fetch_model (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ready_in,
   output logic             valid_out,
   output logic [31:0]      insn_out
);
   logic [31:0] words[$];
   logic        took;
   task automatic push(input logic [31:0] w);
      words.push_back(w);
   endtask
   initial begin
      valid_out = 1'b0;
      insn_out = 32'h0;
      took = 1'b0;
   end
   always @(posedge clk_in) took <= valid_out && ready_in && !sys_rst_in;
   // offer held until taken, idle word churns
   always @(negedge clk_in) begin
      if (sys_rst_in) begin
         valid_out <= 1'b0;
      end else if (!valid_out || took) begin
         if (words.size() > 0) begin
            insn_out <= words.pop_front();
            valid_out <= 1'b1;
         end else begin
            valid_out <= 1'b0;
            insn_out <= ~insn_out;
         end
      end
   end
endmodule // ifd_fetch_model

// [tb_instruction_format_operand_decode.sv]
// testbench for the instruction format and operand decoder
`timescale 1ns/10ps
module tb_instruction_format_operand_decode;
   import ifd_pkg::*;
   logic clk_in, sys_rst_in, exec_ready_in, iv, rdy_n, rdy_w;
   logic [31:0] iw;
   logic dv_n, dv_w, bu_n, dw_n, pf_n, pf_w;
   ifd_fmt_t fmt_n;
   ifd_spr_sel_t sel_n;
   logic [4:0] ra_n, rb_n, rd_n;
   logic [3:0] vx_n;
   logic [13:0] spr_n;
   logic [31:0] imm_n, sm_n, dm_n;
   logic [63:0] imm_w, sm_w, dm_w;
   int fails = 0;
   int compares = 0;
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   ifd_fetch_model ifd_fetch_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .ready_in(rdy_n), .valid_out(iv), .insn_out(iw));
   ifd_decoder ifd_decoder_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .insn_valid_in(iv), .insn_in(iw), .insn_ready_out(rdy_n),
      .exec_ready_in(exec_ready_in), .dec_valid_out(dv_n), .fmt_out(fmt_n),
      .first_source_reg_out(ra_n), .second_source_reg_out(rb_n),
      .dest_reg_out(rd_n), .second_source_used_out(bu_n),
      .dest_write_out(dw_n), .imm_out(imm_n), .imm_prefixed_out(pf_n),
      .src_mask_out(sm_n), .dest_mask_out(dm_n),
      .special_register_number_out(spr_n), .spr_sel_out(sel_n),
      .version_idx_out(vx_n));
   ifd_decoder #(.DATA_W(64)) ifd_decoder_wide_i (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .insn_valid_in(iv), .insn_in(iw),
      .insn_ready_out(rdy_w), .exec_ready_in(exec_ready_in),
      .dec_valid_out(dv_w), .fmt_out(), .first_source_reg_out(),
      .second_source_reg_out(), .dest_reg_out(), .second_source_used_out(),
      .dest_write_out(), .imm_out(imm_w), .imm_prefixed_out(pf_w),
      .src_mask_out(sm_w), .dest_mask_out(dm_w),
      .special_register_number_out(), .spr_sel_out(), .version_idx_out());
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_dec;
      int n;
      n = 0;
      while (dv_n !== 1'b1 && n < 30) begin
         @(negedge clk_in);
         n++;
      end
      chk(dv_w, 1'b1);
   endtask
   task automatic expect_dec(input logic f, input logic [4:0] d, a, b,
                             input logic [63:0] im, input logic p, wd);
      logic [63:0] wm;
      wm = wd ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
      wait_dec();
      chk(fmt_n, f);
      chk(rd_n, d);
      chk(ra_n, a);
      if (!f) chk(rb_n, b);
      chk(bu_n, !f);
      chk(dw_n, 1'b1);
      if (f) chk(imm_n, im[31:0]);
      if (f) chk(imm_w, im);
      chk(pf_n, p);
      chk(pf_w, p);
      chk({sm_n, dm_n}, 64'hFFFFFFFFFFFFFFFF);
      chk(sm_w, wm);
      chk(dm_w, wm);
      @(negedge clk_in);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reg;
      ifd_fetch_model_i.push({6'h00, 5'd31, 5'd0, 5'd17, 11'h000});
      ifd_fetch_model_i.push({6'h00, 5'd0, 5'd31, 5'd1, 11'h100});
      expect_dec(1'b0, 5'd31, 5'd0, 5'd17, 64'h0, 1'b0, 1'b0);
      expect_dec(1'b0, 5'd0, 5'd31, 5'd1, 64'h0, 1'b0, 1'b1);
   endtask
   task automatic t_imm;
      ifd_fetch_model_i.push({6'h28, 5'd3, 5'd4, 16'h8001});
      ifd_fetch_model_i.push({6'h2C, 10'h000, 16'h8765});
      ifd_fetch_model_i.push({6'h28, 5'd5, 5'd6, 16'h1234});
      ifd_fetch_model_i.push({6'h28, 5'd7, 5'd8, 16'h0042});
      ifd_fetch_model_i.push({6'h2C, 10'h000, 16'h1111});
      ifd_fetch_model_i.push({6'h00, 5'd9, 5'd2, 5'd1, 11'h000});
      ifd_fetch_model_i.push({6'h28, 5'd1, 5'd2, 16'h7FFF});
      expect_dec(1'b1, 5'd3, 5'd4, 5'd0, 64'hFFFFFFFFFFFF8001, 1'b0, 1'b0);
      expect_dec(1'b1, 5'd5, 5'd6, 5'd0, 64'hFFFFFFFF87651234, 1'b1, 1'b0);
      expect_dec(1'b1, 5'd7, 5'd8, 5'd0, 64'h42, 1'b0, 1'b0);
      expect_dec(1'b0, 5'd9, 5'd2, 5'd1, 64'h0, 1'b0, 1'b0);
      expect_dec(1'b1, 5'd1, 5'd2, 5'd0, 64'h7FFF, 1'b0, 1'b1);
   endtask
   task automatic t_spr;
      logic [13:0] num[9] = '{14'h0000, 14'h0001, 14'h0003, 14'h0005,
         14'h0007, 14'h000B, 14'h2000, 14'h200C, 14'h0002};
      logic [3:0] sel[9] = '{4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h7, 4'h6,
         4'h6, 4'h0};
      for (int i = 0; i < 9; i++)
         ifd_fetch_model_i.push({6'h25, 12'h0, num[i]});
      for (int i = 0; i < 9; i++) begin
         wait_dec();
         chk(spr_n, num[i]);
         chk(sel_n, sel[i]);
         if (sel[i] == 4'h6) chk(vx_n, num[i][3:0]);
         @(negedge clk_in);
      end
   endtask
   task automatic t_stall;
      exec_ready_in = 1'b0;
      ifd_fetch_model_i.push({6'h00, 5'd11, 5'd12, 5'd13, 11'h000});
      ifd_fetch_model_i.push({6'h00, 5'd14, 5'd15, 5'd16, 11'h000});
      wait_dec();
      repeat (3) @(negedge clk_in);
      chk({rdy_n, rdy_w, rd_n}, {2'b00, 5'd11});
      exec_ready_in = 1'b1;
      expect_dec(1'b0, 5'd11, 5'd12, 5'd13, 64'h0, 1'b0, 1'b0);
      expect_dec(1'b0, 5'd14, 5'd15, 5'd16, 64'h0, 1'b0, 1'b0);
   endtask
   task automatic t_reset;
      ifd_fetch_model_i.push({6'h2C, 10'h000, 16'h5555});
      repeat (3) @(negedge clk_in);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      chk({dv_n, rdy_n, pf_n, pf_w}, 4'b0100);
      sys_rst_in = 1'b0;
      ifd_fetch_model_i.push({6'h28, 5'd2, 5'd3, 16'h0001});
      expect_dec(1'b1, 5'd2, 5'd3, 5'd0, 64'h1, 1'b0, 1'b0);
   endtask
   task automatic final_report;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #160000;
      fails++;
      final_report();
   end
   initial begin
      sys_rst_in = 1'b1;
      exec_ready_in = 1'b1;
      repeat (10) @(negedge clk_in);
      sys_rst_in = 1'b0;
      chk({dv_n, rdy_n}, 2'b01);
      t_reg();
      t_imm();
      t_spr();
      t_stall();
      t_reset();
      final_report();
   end
endmodule // tb_instruction_format_operand_decode
